// ### mode_select_pkg.sv
/*
  package for the phase count and conduction mode selection block:
  mode codes, slew table, timing constants and carrier structs.
  assumes nothing beyond a systemverilog package scope.
*/
package mode_select_pkg;

  // apb register offsets (byte addresses, one word each)
  localparam logic [7:0] ctrl_off = 8'h00;
  localparam logic [7:0] vcode_off = 8'h04;
  localparam logic [7:0] status_off = 8'h08;
  localparam logic [7:0] target_off = 8'h0c;
  localparam logic [7:0] balance_off = 8'h10;
  localparam logic [7:0] thresh_off = 8'h14;

  // control register fields
  localparam int ctrl_hint_a_bit = 0;
  localparam int ctrl_hint_b_bit = 1;
  localparam int ctrl_start_bit = 2;
  localparam logic [1:0] hint_reset = 2'h3;

  // voltage code width and reset value
  localparam int vcode_w = 8;
  localparam logic [7:0] vcode_reset = 8'h00;
  // one code step is 6.25 mV, expressed in microvolts
  localparam int step_uv = 6250;

  // slew rates in uV/us, indexed by the two slew strap bits
  localparam int slew_uv_per_us [4] = '{10000, 12500, 15000, 20000};

  // clock
  localparam int clk_mhz = 100;

  // body-diode conduction target
  localparam int diode_target_ns = 40;
  localparam int clk_period_ns = 10;
  localparam int diode_target_cyc = (diode_target_ns + clk_period_ns - 1)
                                    / clk_period_ns;

  // zero-cross threshold trim range
  localparam int thresh_w = 6;
  localparam logic [5:0] thresh_reset = 6'h20;

  // pulse-width trim range per phase (signed)
  localparam int trim_w = 6;

  // per-rail conduction summary
  typedef struct packed {
    logic enabled;      // rail output allowed to switch
    logic [3:0] phases; // one bit per active phase
    logic diode_mode;   // diode emulation instead of continuous
  } rail_mode_type;

  // strap pins, a high sense-tied bit means tied to the 5 V supply; slew_sel picks the rate
  typedef struct packed {
    logic [3:0] main_sense_tied;
    logic [1:0] aux_sense_tied;
    logic [1:0] slew_sel;
  } strap_type;

endpackage : mode_select_pkg

// ### sync2.sv
/*
  two flip-flop synchroniser for a bus of level inputs.
  assumes the inputs change slowly with respect to pclk.
*/
`timescale 1ns/1ps
module sync2 #(
  parameter int width = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [width-1:0] async_in,
  output logic [width-1:0] sync_out
);

  typedef struct packed {
    logic [width-1:0] first;
    logic [width-1:0] second;
  } state_type;

  state_type state_reg;
  state_type state_next;

  // the first stage feeds only the second stage
  always_comb begin
    state_next = state_reg;
    state_next.first = async_in;
    state_next.second = state_reg.first;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_out = state_reg.second;

endmodule : sync2

// ### rail_slew.sv
/*
  target voltage ramp for one rail: steps the target code toward the
  commanded code on each slew enable pulse when rising, and jumps down
  at once when falling so the load sets the fall rate.
  assumes the slew enable pulse comes from a divider in the parent.
*/
`timescale 1ns/1ps
module rail_slew
  import mode_select_pkg::*;
#(
  parameter int code_w = vcode_w
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slew_tick,
  input wire logic [code_w-1:0] commanded_code,
  output logic [code_w-1:0] target_code,
  output logic ramping
);

  typedef struct packed {
    logic [code_w-1:0] target;
  } state_type;

  state_type state_reg;
  state_type state_next;

  // upward moves step one code per tick; downward moves do not drive
  // the output down, the target simply drops and the load discharges
  always_comb begin
    state_next = state_reg;
    if (commanded_code < state_reg.target) begin
      state_next.target = commanded_code;
    end else if (slew_tick && commanded_code > state_reg.target) begin
      state_next.target = state_reg.target + code_w'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign target_code = state_reg.target;
  assign ramping = commanded_code > state_reg.target;

endmodule : rail_slew

// ### phase_count_mode_select.sv
/*
  phase count and conduction mode selection for a two-rail multiphase
  buck controller, with slew control, phase balancing and zero-cross
  threshold trimming, reached over apb.
  assumes strap and comparator inputs are asynchronous pins, the apb
  master keeps to the apb protocol, and pclk runs at 100 mhz.
*/
// Design decisions made here: register access over APB and the placing of the registers.
// Notes on behaviour
// - sense pin tied high disables its phase
// - four-phase main: 11 four, 01 two, 00 diode
// - three-phase main, hints 11: three phases continuous
// - three-phase main, hint a low: drop phase three
// - three-phase main, both low: single diode emulation
// - two-phase main: 11 two, 01 one continuous
// - two-phase main, both low: single diode emulation
// - single-phase main: diode only when both low
// - first main sense tied high disables main rail
// - two-phase aux: 11 two, 01 one, 00 diode
// - single-phase aux: diode only when both low
// - first aux sense tied high disables aux rail
// - both rails ramp up at programmed slew rate
// - downward change not actively driven down
// - trim pulse widths until phase senses equal
// - main rail diode mode turns low side off at zero
// - step zero-cross threshold toward 40 ns diode time
// - slew rate latched at start, shared, fixed
`timescale 1ns/1ps
module phase_count_mode_select
  import mode_select_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire mode_select_pkg::strap_type strap_pins,
  input wire logic [3:0] phase_above_avg,
  input wire logic low_side_zero,
  input wire logic diode_seen,
  output mode_select_pkg::rail_mode_type main_mode,
  output mode_select_pkg::rail_mode_type aux_mode,
  output logic [vcode_w-1:0] main_target,
  output logic [vcode_w-1:0] aux_target,
  output logic low_side_off,
  output logic [thresh_w-1:0] zero_thresh,
  output logic [4*trim_w-1:0] phase_trim
);

  import mode_select_pkg::*;

  localparam int strap_w = $bits(strap_type);
  localparam int slew_div_w = 16;

  // slew step period in cycles: one code step at the chosen rate
  function automatic logic [slew_div_w-1:0] slew_period(
    input logic [1:0] sel
  );
    int cyc;
    cyc = (step_uv * clk_mhz) / slew_uv_per_us[sel];
    if (cyc < 1) begin
      cyc = 1;
    end
    return slew_div_w'(cyc);
  endfunction : slew_period

  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_latch = 3'b010,
    st_run = 3'b100
  } phase_state_type;

  typedef struct packed {
    phase_state_type fsm;
    strap_type straps;
    logic [1:0] hint;
    logic [vcode_w-1:0] vcode;
    logic [slew_div_w-1:0] slew_cnt;
    logic slew_tick;
    logic [3:0] diode_cnt;
    logic ls_on;
    logic [thresh_w-1:0] thresh;
    logic [4*trim_w-1:0] trim;
    rail_mode_type main_m;
    rail_mode_type aux_m;
    logic [31:0] rdata;
  } state_type;

  state_type state_reg;
  state_type state_next;

  strap_type strap_sync;
  logic [3:0] above_sync;
  logic zero_sync;
  logic diode_sync;
  logic [vcode_w-1:0] main_tgt;
  logic [vcode_w-1:0] aux_tgt;
  logic main_ramp;
  logic aux_ramp;
  logic [1:0] eff_hint;
  rail_mode_type main_calc;
  rail_mode_type aux_calc;
  logic wr_en;
  logic rd_en;

  // all pins cross into pclk before use
  sync2 #(.width(strap_w + 6)) pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({strap_pins, phase_above_avg, low_side_zero, diode_seen}),
    .sync_out({strap_sync, above_sync, zero_sync, diode_sync})
  );

  rail_slew #(.code_w(vcode_w)) main_slew (
    .pclk(pclk),
    .presetn(presetn),
    .slew_tick(state_reg.slew_tick),
    .commanded_code(state_reg.vcode),
    .target_code(main_tgt),
    .ramping(main_ramp)
  );

  // same tick and code: both rails move identically
  rail_slew #(.code_w(vcode_w)) aux_slew (
    .pclk(pclk),
    .presetn(presetn),
    .slew_tick(state_reg.slew_tick),
    .commanded_code(state_reg.vcode),
    .target_code(aux_tgt),
    .ramping(aux_ramp)
  );

  // undefined 10 (hint a high, hint b low) behaves like 11
  assign eff_hint = (state_reg.hint == 2'h1) ? 2'h3 : state_reg.hint;

  // main rail mode table; hint[0] is hint a, hint[1] is hint b
  always_comb begin
    logic [3:0] cfg;
    cfg = ~state_reg.straps.main_sense_tied;
    main_calc = '0;
    main_calc.enabled = cfg[0];
    if (eff_hint == 2'h3) begin
      // full configured set; a tied phase drops out of the count
      if (cfg[1] && cfg[2] && cfg[3]) begin
        main_calc.phases = 4'hf;
      end else if (cfg[1] && cfg[2]) begin
        main_calc.phases = 4'h7;
      end else if (cfg[1]) begin
        main_calc.phases = 4'h3;
      end else begin
        main_calc.phases = 4'h1;
      end
    end else if (eff_hint == 2'h2) begin
      // hint a low: two phases wherever the third phase sense pin is not tied high
      main_calc.phases = cfg[2] ? 4'h3 : 4'h1;
    end else begin
      main_calc.phases = 4'h1;
      main_calc.diode_mode = 1'b1;
    end
    if (!main_calc.enabled) begin
      main_calc.phases = 4'h0;
      main_calc.diode_mode = 1'b0;
    end
  end

  // aux rail mode table
  always_comb begin
    logic [1:0] acfg;
    acfg = ~state_reg.straps.aux_sense_tied;
    aux_calc = '0;
    aux_calc.enabled = acfg[0];
    if (eff_hint == 2'h3 && acfg[1]) begin
      aux_calc.phases = 4'h3;
    end else begin
      aux_calc.phases = 4'h1;
    end
    aux_calc.diode_mode = (eff_hint == 2'h0);
    if (!aux_calc.enabled) begin
      aux_calc.phases = 4'h0;
      aux_calc.diode_mode = 1'b0;
    end
  end

  // apb decode: zero wait states
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(paddr == ctrl_off ||
                   paddr == vcode_off || paddr == status_off ||
                   paddr == target_off || paddr == balance_off ||
                   paddr == thresh_off);

  always_comb begin
    logic [trim_w-1:0] t;
    t = '0;
    state_next = state_reg;
    state_next.slew_tick = 1'b0;
    state_next.main_m = main_calc;
    state_next.aux_m = aux_calc;

    // start-up: straps and slew are captured once, then held
    case (state_reg.fsm)
      st_idle: begin
        if (wr_en && paddr == ctrl_off && pwdata[ctrl_start_bit]) begin
          state_next.fsm = st_latch;
        end
      end
      st_latch: begin
        state_next.straps = strap_sync;
        state_next.fsm = st_run;
      end
      st_run: begin
        state_next.fsm = st_run;
      end
      default: begin
        state_next.fsm = st_idle;
      end
    endcase

    // hint bits come with each accepted command and re-select modes
    if (wr_en && paddr == ctrl_off) begin
      state_next.hint = {pwdata[ctrl_hint_b_bit],
                         pwdata[ctrl_hint_a_bit]};
    end
    if (wr_en && paddr == vcode_off) begin
      state_next.vcode = pwdata[vcode_w-1:0];
    end

    // slew divider runs only once the rate is latched
    if (state_reg.fsm == st_run) begin
      if (state_reg.slew_cnt >=
          slew_period(state_reg.straps.slew_sel) - slew_div_w'(1)) begin
        state_next.slew_cnt = '0;
        state_next.slew_tick = 1'b1;
      end else begin
        state_next.slew_cnt = state_reg.slew_cnt + slew_div_w'(1);
      end
    end

    // balance: shorten phases above average, lengthen the others
    for (int i = 0; i < 4; i++) begin
      t = state_reg.trim[i*trim_w +: trim_w];
      if (state_reg.slew_tick && state_reg.main_m.phases[i]) begin
        if (above_sync[i] && t != {1'b1, {(trim_w-1){1'b0}}}) begin
          t = t - trim_w'(1);
        end else if (!above_sync[i] && t != {1'b0, {(trim_w-1){1'b1}}})
        begin
          t = t + trim_w'(1);
        end
      end
      state_next.trim[i*trim_w +: trim_w] = t;
    end

    // low side follows zero-cross only in diode emulation
    state_next.ls_on = !(state_reg.main_m.diode_mode && zero_sync);

    // measure diode time after low-side turn-off and trim threshold;
    // the low side may already be back on, so the diode pin alone
    // bounds the episode
    if (diode_sync) begin
      if (state_reg.diode_cnt != 4'hf) begin
        state_next.diode_cnt = state_reg.diode_cnt + 4'h1;
      end
    end else if (state_reg.diode_cnt != 4'h0) begin
      // diode episode over: longer than target, trip earlier
      if (state_reg.diode_cnt > 4'(diode_target_cyc) &&
          state_reg.thresh != '0) begin
        state_next.thresh = state_reg.thresh - thresh_w'(1);
      end else if (state_reg.diode_cnt < 4'(diode_target_cyc) &&
                   state_reg.thresh != '1) begin
        state_next.thresh = state_reg.thresh + thresh_w'(1);
      end
      state_next.diode_cnt = 4'h0;
    end

    // read data registered in the setup cycle
    if (rd_en) begin
      state_next.rdata = '0;
      case (paddr)
        ctrl_off: state_next.rdata[1:0] = state_reg.hint;
        vcode_off: state_next.rdata[vcode_w-1:0] = state_reg.vcode;
        status_off: state_next.rdata = {13'h0, aux_ramp, main_ramp,
                                        2'h0, state_reg.fsm,
                                        state_reg.aux_m,
                                        state_reg.main_m};
        target_off: state_next.rdata = {16'h0, aux_tgt, main_tgt};
        balance_off: state_next.rdata[4*trim_w-1:0] = state_reg.trim;
        thresh_off: state_next.rdata[thresh_w-1:0] = state_reg.thresh;
        default: state_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
      state_reg.fsm <= st_idle;
      state_reg.hint <= hint_reset;
      state_reg.vcode <= vcode_reset;
      state_reg.thresh <= thresh_reset;
      state_reg.ls_on <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign prdata = state_reg.rdata;
  assign main_mode = state_reg.main_m;
  assign aux_mode = state_reg.aux_m;
  assign main_target = main_tgt;
  assign aux_target = aux_tgt;
  assign low_side_off = !state_reg.ls_on;
  assign zero_thresh = state_reg.thresh;
  assign phase_trim = state_reg.trim;

endmodule : phase_count_mode_select

// ### mode_exp_pkg.sv
/*
  expected phase masks and conduction modes, worked out from strap
  counts and hint bits. assumes hint vector {hint b, hint a}.
*/
package mode_exp_pkg;

  // phase count set by the lowest sense pin tied high above the first
  function automatic int main_n(logic [3:0] t);
    return t[1] ? 1 : t[2] ? 2 : t[3] ? 3 : 4;
  endfunction : main_n

  // returns {phase mask, diode mode}; hint 01 keeps all phases
  function automatic logic [4:0] exp_mode(int n, logic [1:0] h);
    if (!h[0]) begin
      n = h[1] ? (n + 1) / 2 : 1;
    end
    return {4'((1 << n) - 1), h == 2'b00};
  endfunction : exp_mode

endpackage : mode_exp_pkg

// ### power_stage_model.sv
/*
  power stage seen by the block: phase comparators and the body diode.
  assumes the bench sets how long the diode conducts after turn-off.
*/
`timescale 1ns/1ps
module power_stage_model (
  input wire logic pclk,
  input wire logic low_side_off,
  input wire logic [3:0] hot_phases,
  input wire logic [3:0] diode_len,
  output logic low_side_zero,
  output logic diode_seen,
  output logic [3:0] phase_above_avg
);
  logic [4:0] t = '0;
  logic [3:0] left = '0;
  logic off_d = 1'b0;

  // diode conducts a set time after each low-side turn-off
  always @(posedge pclk) begin
    t <= t + 5'h01;
    off_d <= low_side_off;
    if (low_side_off && !off_d) begin
      left <= diode_len;
    end else if (left != 4'h0) begin
      left <= left - 4'h1;
    end
  end

  // zero crossing once every 32 cycles, as at light load
  assign low_side_zero = (t[4:2] == 3'h0);
  assign diode_seen = (left != 4'h0);
  assign phase_above_avg = hot_phases;
endmodule : power_stage_model

// ### phase_count_mode_select_checker.sv
/*
  concurrent checks on the mode selection block's ports.
  assumes straps are steady from reset and one start write per reset.
*/
`timescale 1ns/1ps
module phase_count_mode_select_checker
  import mode_select_pkg::*;
  import mode_exp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire mode_select_pkg::strap_type strap_pins,
  input wire mode_select_pkg::rail_mode_type main_mode,
  input wire mode_select_pkg::rail_mode_type aux_mode,
  input wire logic [vcode_w-1:0] main_target,
  input wire logic [vcode_w-1:0] aux_target,
  input wire logic low_side_off,
  input wire logic [thresh_w-1:0] zero_thresh
);
  logic [1:0] hq;
  logic [3:0] sc;
  logic [1:0] qc;
  logic wr;
  logic ok;

  // track hints and time since start so modes are judged once settled
  assign wr = psel && penable && pwrite && paddr == ctrl_off;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hq <= hint_reset;
      sc <= 4'h0;
      qc <= 2'h0;
    end else begin
      hq <= wr ? pwdata[1:0] : hq;
      qc <= wr ? 2'h0 : (qc == 2'h3 ? qc : qc + 2'h1);
      sc <= (wr && pwdata[2]) ? 4'h1 :
            ((sc == 4'h0 || sc == 4'hf) ? sc : sc + 4'h1);
    end
  end
  assign ok = sc == 4'hf && qc == 2'h3;

  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_main_en;
    sc == 4'hf |-> main_mode.enabled == !strap_pins.main_sense_tied[0];
  endproperty
  a_main_en: assert property (p_main_en)
    else $error("main rail enable disagrees with strap");
  property p_aux_en;
    sc == 4'hf |-> aux_mode.enabled == !strap_pins.aux_sense_tied[0];
  endproperty
  a_aux_en: assert property (p_aux_en)
    else $error("aux rail enable disagrees with strap");
  property p_main_mode;
    ok && main_mode.enabled |-> {main_mode.phases, main_mode.diode_mode}
      == exp_mode(main_n(strap_pins.main_sense_tied), hq);
  endproperty
  a_main_mode: assert property (p_main_mode)
    else $error("main rail phases or mode wrong");
  property p_aux_mode;
    ok && aux_mode.enabled |-> {aux_mode.phases, aux_mode.diode_mode}
      == exp_mode(strap_pins.aux_sense_tied[1] ? 1 : 2, hq);
  endproperty
  a_aux_mode: assert property (p_aux_mode)
    else $error("aux rail phases or mode wrong");
  property p_same;
    main_mode.enabled && aux_mode.enabled |-> main_target == aux_target;
  endproperty
  a_same: assert property (p_same)
    else $error("rail targets differ");
  property p_rate;
    main_target > $past(main_target) |->
      main_target == $past(main_target) + 8'h01 ##1 $stable(main_target)[*8];
  endproperty
  a_rate: assert property (p_rate)
    else $error("upward ramp step too large or too fast");
  property p_thresh;
    $changed(zero_thresh) |-> zero_thresh == $past(zero_thresh) + 6'h01
      || zero_thresh == $past(zero_thresh) - 6'h01;
  endproperty
  a_thresh: assert property (p_thresh)
    else $error("threshold moved by more than one step");
  property p_lso;
    low_side_off |-> main_mode.diode_mode || aux_mode.diode_mode
      || $past(main_mode.diode_mode) || $past(aux_mode.diode_mode);
  endproperty
  a_lso: assert property (p_lso)
    else $error("low side forced off outside diode mode");
endmodule : phase_count_mode_select_checker

bind phase_count_mode_select phase_count_mode_select_checker u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .strap_pins(strap_pins), .main_mode(main_mode), .aux_mode(aux_mode),
  .main_target(main_target), .aux_target(aux_target),
  .low_side_off(low_side_off), .zero_thresh(zero_thresh)
);

// ### tb.sv
/*
  self-checking bench for the mode selection block with a power stage.
  assumes zero-wait apb and one strap setup per reset.
*/
`timescale 1ns/1ps
module tb;
  import mode_select_pkg::*;
  import mode_exp_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic pready, pslverr, lso, lsz, dseen, er;
  logic [7:0] paddr = 0, mt, at;
  logic [31:0] pwdata = 0, prdata, rd;
  strap_type straps = '0;
  rail_mode_type mm, am;
  logic [3:0] above, hot = 0, dlen = 0;
  logic [5:0] th, th0;
  logic [23:0] trim;
  logic [7:0] tab [5] = '{8'h00, 8'h89, 8'hc6, 8'he3, 8'h18};
  int fail_count = 0, checked = 0;

  always #5 pclk = ~pclk;

  phase_count_mode_select u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .strap_pins(straps), .phase_above_avg(above), .low_side_zero(lsz),
    .diode_seen(dseen), .main_mode(mm), .aux_mode(am), .main_target(mt),
    .aux_target(at), .low_side_off(lso), .zero_thresh(th),
    .phase_trim(trim));
  power_stage_model u_ps (.pclk(pclk), .low_side_off(lso),
    .hot_phases(hot), .diode_len(dlen), .low_side_zero(lsz),
    .diode_seen(dseen), .phase_above_avg(above));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // hold the request until pready is seen high; give up and count a failure after 50 cycles
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    if (n >= 50) fail_count++;
  endtask : apb

  // straps settle during reset, then the start bit latches them
  task cfg(input logic [7:0] s);
    @(posedge pclk);
    presetn <= 0;
    straps <= s;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    apb(1, ctrl_off, 32'h7);
    repeat (4) @(posedge pclk);
  endtask : cfg

  task t_modes;
    for (int h = 0; h < 4; h++) begin
      apb(1, ctrl_off, 32'(h));
      repeat (3) @(posedge pclk);
      #1;
      chk(mm.enabled, !straps.main_sense_tied[0]);
      chk(am.enabled, !straps.aux_sense_tied[0]);
      if (mm.enabled) chk({mm.phases, mm.diode_mode},
        exp_mode(main_n(straps.main_sense_tied), 2'(h)));
      if (am.enabled) chk({am.phases, am.diode_mode},
        exp_mode(straps.aux_sense_tied[1] ? 1 : 2, 2'(h)));
    end
    $display("modes done for straps %h", straps);
  endtask : t_modes

  task t_slew(input int sel);
    int p, n;
    p = step_uv * clk_mhz / slew_uv_per_us[sel];
    apb(1, vcode_off, 32'h2);
    n = 0;
    while (mt !== 8'h02 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    chk(n >= p && n <= 2 * p + 4, 1);
    if (mm.enabled && am.enabled) chk(at, mt);
    // commanded code reads back; chk keeps only 32 bits, so er is dropped and not compared
    apb(0, vcode_off, 32'h0);
    chk({er, rd}, {1'b0, 32'h2});
    repeat (8) @(posedge pclk);
    apb(1, vcode_off, 32'h0);
    repeat (2) @(posedge pclk);
    #1 chk(mt, 0);
    $display("slew done for rate index %0d", sel);
  endtask : t_slew

  // long diode time pulls the threshold down, short pushes it up
  task t_diode;
    hot <= 4'b0001;
    dlen <= 4'h8;
    apb(1, ctrl_off, 32'h0);
    repeat (400) @(posedge pclk);
    #1 th0 = th;
    chk(th0 < 6'h20, 1);
    dlen <= 4'h1;
    repeat (800) @(posedge pclk);
    #1 chk(th > th0, 1);
    chk(trim[5], 1);
    chk(!trim[11] && trim[11:6] != 6'h00, 1);
    apb(1, 8'h40, 32'h1);
    chk(er, 1);
    apb(0, 8'h40, 32'h0);
    chk({er, rd}, {1'b1, 32'h0});
    $display("diode, balance and refusal done");
  endtask : t_diode

  task close_out;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out

  initial begin
    for (int i = 0; i < 5; i++) begin
      cfg(tab[i]);
      t_modes;
      if (i < 4) t_slew(i);
      if (i == 0) t_diode;
    end
    close_out;
  end

  // the whole run needs a few thousand cycles
  initial begin
    repeat (30000) @(posedge pclk);
    fail_count++;
    close_out;
  end
endmodule : tb
